// File: hw/emw_regs.svh
`ifndef EMW_REGS_SVH
`define EMW_REGS_SVH

// Register byte offsets.
`define EMW_WCR_OFS 32'h0000_0000
`define EMW_STAT_OFS 32'h0000_0004

// Wait control field positions.
`define EMW_BW_LSB 16
`define EMW_W_LSB 7
`define EMW_WM_BIT 6

// Wait control reset value and writable-bit mask.
`define EMW_WCR_RST 32'h0000_0500
`define EMW_WCR_MASK 32'h0003_07c0

// AXI response codes.
`define EMW_RESP_OKAY 2'h0
`define EMW_RESP_DECERR 2'h3

`endif

// File: hw/emw_pkg.sv
package emw_pkg;

  typedef struct packed {
    logic [1:0] burst_follow_wait_count;
    logic [3:0] access_wait_count;
    logic external_wait_ignore;
  } emw_wcr_t;

  typedef enum logic [3:0] {
    EMW_IDLE = 4'h1,
    EMW_WAIT = 4'h2,
    EMW_HOLD = 4'h4,
    EMW_BEAT = 4'h8
  } emw_state_t;

  typedef struct packed {
    logic [25:0] log_addr;
    logic col_phase;
    logic ap_level;
  } emw_mux_req_t;

endpackage

// File: hw/emw_addr_mux.sv
`timescale 1ns/1ps

// Multiplexes the logical address onto the memory address pins.
module emw_addr_mux (
  input wire emw_pkg::emw_mux_req_t req,
  output logic [17:0] pin_addr
);

  function automatic logic [17:0] emw_map(input emw_pkg::emw_mux_req_t r);
    logic [17:0] a;
    a = 18'h0;
    if (r.col_phase) begin
      a = r.log_addr[17:0];
      a[13] = r.log_addr[21];
      a[12] = r.log_addr[20];
      a[11] = r.ap_level;
    end else begin
      a = r.log_addr[25:8];
    end
    return a;
  endfunction

  always_comb begin
    pin_addr = emw_map(req);
  end

endmodule // emw_addr_mux

// File: hw/emw_top.sv
// Behaviour
// - Mask bit clear honours external wait input; mask bit set ignores it entirely.
// - Mask applies even with zero programmed wait; external wait then does not stretch access.
// - Burst wait field gives 0 to 3 waits on later beats; resets to 00.
// - Reserved bits 31-18 and 5-0 read zero; software writes zero to them.
// - Row phase drives address 25-8; column drives 10-0; banks 21,20 on 13,12.
// - Column phase pin 11 carries fixed precharge command level, not an address bit.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "emw_regs.svh"

module emw_top (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic ACC_START,
  input wire logic [1:0] ACC_BEATS,
  output logic ACC_BEAT_DONE,
  output logic ACC_BUSY,
  input wire logic EXT_WAIT_B,
  input wire logic [25:0] LOG_ADDR,
  input wire logic COL_PHASE,
  input wire logic AP_LEVEL,
  output logic [17:0] MEM_ADDR
);

  emw_pkg::emw_wcr_t wcr;
  emw_pkg::emw_state_t state;
  emw_pkg::emw_state_t next_state;
  emw_pkg::emw_mux_req_t mux_req;
  logic [17:0] mux_addr;
  logic wait_meta;
  logic wait_sync;
  logic [3:0] wait_cnt;
  logic [3:0] next_wait_cnt;
  logic [1:0] beats_left;
  logic [1:0] next_beats_left;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic ext_stall;
  logic wr_fire;
  logic [31:0] wcr_merged;
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  function automatic logic [31:0] emw_wcr_word(input emw_pkg::emw_wcr_t r);
    logic [31:0] v;
    v = 32'h0;
    v[`EMW_BW_LSB +: 2] = r.burst_follow_wait_count;
    v[`EMW_W_LSB +: 4] = r.access_wait_count;
    v[`EMW_WM_BIT] = r.external_wait_ignore;
    return v & `EMW_WCR_MASK;
  endfunction

  function automatic logic [31:0] emw_byte_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic emw_is_reg(input logic [31:0] addr, input logic [31:0] ofs);
    return addr[31:2] == ofs[31:2];
  endfunction

  function automatic logic emw_known(input logic [31:0] addr);
    return emw_is_reg(addr, `EMW_WCR_OFS) || emw_is_reg(addr, `EMW_STAT_OFS);
  endfunction

  // External wait pin is asynchronous; two flip-flops before use.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_meta <= 1'b0;
      wait_sync <= 1'b0;
    end else begin
      wait_meta <= ~EXT_WAIT_B;
      wait_sync <= wait_meta;
    end
  end

  // Stall request is only honoured while the mask bit is clear.
  always_comb begin
    ext_stall = wait_sync & ~wcr.external_wait_ignore;
  end

  // Write address channel.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      aw_held <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
    end
  end

  // Write data channel.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      w_held <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end
  end

  // Write response once both halves are held.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `EMW_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      if (emw_known(aw_addr)) begin
        S_AXI_BRESP <= `EMW_RESP_OKAY;
      end else begin
        S_AXI_BRESP <= `EMW_RESP_DECERR;
      end
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // A held address and data pair commits once, on the edge that raises the response.
  always_comb begin
    wr_fire = aw_held & w_held & ~S_AXI_BVALID & ~S_AXI_AWREADY;
  end

  // Byte lanes that are not enabled keep the current register contents.
  always_comb begin
    wcr_merged = (emw_wcr_word(wcr) & ~emw_byte_mask(w_strb))
               | (w_data & emw_byte_mask(w_strb));
  end

  // Wait control register; only the documented fields store.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wcr.burst_follow_wait_count <= 2'(`EMW_WCR_RST >> `EMW_BW_LSB);
      wcr.access_wait_count <= 4'(`EMW_WCR_RST >> `EMW_W_LSB);
      wcr.external_wait_ignore <= 1'(`EMW_WCR_RST >> `EMW_WM_BIT);
    end else if (wr_fire && emw_is_reg(aw_addr, `EMW_WCR_OFS)) begin
      wcr.burst_follow_wait_count <= wcr_merged[`EMW_BW_LSB +: 2];
      wcr.access_wait_count <= wcr_merged[`EMW_W_LSB +: 4];
      wcr.external_wait_ignore <= wcr_merged[`EMW_WM_BIT];
    end
  end

  // Status word: synced wait, beats left, wait count, state and busy.
  always_comb begin
    stat_word = {19'h0, wait_sync, beats_left, wait_cnt, state, ACC_BUSY, 1'b0};
  end

  // Read data and response for the address offered on the read channel.
  always_comb begin
    rd_word = 32'h0;
    rd_resp = `EMW_RESP_DECERR;
    if (emw_is_reg(S_AXI_ARADDR, `EMW_WCR_OFS)) begin
      rd_word = emw_wcr_word(wcr);
      rd_resp = `EMW_RESP_OKAY;
    end else if (emw_is_reg(S_AXI_ARADDR, `EMW_STAT_OFS)) begin
      rd_word = stat_word;
      rd_resp = `EMW_RESP_OKAY;
    end
  end

  // Read channel.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `EMW_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= rd_resp;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Access wait sequencer.
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_beats_left = beats_left;
    unique case (state)
      emw_pkg::EMW_IDLE: begin
        if (ACC_START) begin
          next_state = emw_pkg::EMW_WAIT;
          next_wait_cnt = wcr.access_wait_count;
          next_beats_left = ACC_BEATS;
        end
      end
      emw_pkg::EMW_WAIT: begin
        if (wait_cnt != 4'h0) begin
          next_wait_cnt = wait_cnt - 4'h1;
        end else if (ext_stall) begin
          next_state = emw_pkg::EMW_HOLD;
        end else begin
          next_state = emw_pkg::EMW_BEAT;
        end
      end
      emw_pkg::EMW_HOLD: begin
        if (!ext_stall) begin
          next_state = emw_pkg::EMW_BEAT;
        end
      end
      emw_pkg::EMW_BEAT: begin
        if (beats_left == 2'h0) begin
          next_state = emw_pkg::EMW_IDLE;
        end else begin
          next_state = emw_pkg::EMW_WAIT;
          next_wait_cnt = {2'h0, wcr.burst_follow_wait_count};
          next_beats_left = beats_left - 2'h1;
        end
      end
      default: begin
        next_state = emw_pkg::EMW_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= emw_pkg::EMW_IDLE;
      wait_cnt <= 4'h0;
      beats_left <= 2'h0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      beats_left <= next_beats_left;
    end
  end

  // Handshake outputs to the requester.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ACC_BEAT_DONE <= 1'b0;
      ACC_BUSY <= 1'b0;
    end else begin
      ACC_BEAT_DONE <= next_state == emw_pkg::EMW_BEAT;
      ACC_BUSY <= next_state != emw_pkg::EMW_IDLE;
    end
  end

  // Address multiplexing toward the memory.
  always_comb begin
    mux_req.log_addr = LOG_ADDR;
    mux_req.col_phase = COL_PHASE;
    mux_req.ap_level = AP_LEVEL;
  end

  emw_addr_mux u_mux (
    .req(mux_req),
    .pin_addr(mux_addr)
  );

  // Pin 0 is still driven; the attached memory leaves it unconnected.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_ADDR <= 18'h0;
    end else begin
      MEM_ADDR <= mux_addr;
    end
  end

endmodule // emw_top

// File: bench/emw_mem_model.sv
`timescale 1ns/1ps
module emw_mem_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic [17:0] mem_addr,
  output logic ext_wait_b,
  output logic [1:0] bank
);
  logic [7:0] left = 8'h0;
  // Bank inputs sit on pins 13 and 12; pin 0 is never looked at.
  assign bank = mem_addr[13:12];
  // Holds the wait line low for len cycles after each go pulse.
  always_ff @(posedge clk) begin
    if (go) left <= len;
    else if (left != 8'h0) left <= left - 8'h1;
  end
  assign ext_wait_b = (left == 8'h0);
endmodule // emw_mem_model

// File: bench/emw_top_checker.sv
`timescale 1ns/1ps
module emw_top_checker (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic ACC_START,
  input wire logic ACC_BUSY,
  input wire logic ACC_BEAT_DONE,
  input wire logic EXT_WAIT_B,
  input wire logic [25:0] LOG_ADDR,
  input wire logic COL_PHASE,
  input wire logic AP_LEVEL,
  input wire logic [17:0] MEM_ADDR
);
  logic [3:0] sh_w;
  logic sh_m;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // Shadows wait count and mask from each accepted write word.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sh_w <= 4'ha;
      sh_m <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      sh_w <= S_AXI_WDATA[10:7];
      sh_m <= S_AXI_WDATA[6];
    end
  end
  row_map_a: assert property ($past(RST_B) && !$past(COL_PHASE) |->
    MEM_ADDR == $past(LOG_ADDR[25:8])) else $error("row address wrong");
  col_map_a: assert property ($past(RST_B) && $past(COL_PHASE) |->
    MEM_ADDR[13:12] == $past(LOG_ADDR[21:20]) && MEM_ADDR[10:0] == $past(LOG_ADDR[10:0]))
    else $error("column address wrong");
  ap_level_a: assert property ($past(RST_B) && $past(COL_PHASE) |->
    MEM_ADDR[11] == $past(AP_LEVEL)) else $error("precharge level wrong");
  rsvd_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:18] == 14'h0)
    else $error("reserved bits not zero");
  wait_honour_a: assert property ((!EXT_WAIT_B && !sh_m) [*6] |-> !ACC_BEAT_DONE)
    else $error("beat done during external wait");
  first_beat_a: assert property (ACC_START && !ACC_BUSY && sh_m && sh_w == 4'h0 |->
    !ACC_BEAT_DONE [*2] ##1 ACC_BEAT_DONE) else $error("first beat timing wrong");
  start_busy_a: assert property (ACC_START && !ACC_BUSY |=> ACC_BUSY)
    else $error("busy not raised");
  done_busy_a: assert property (ACC_BEAT_DONE |-> ACC_BUSY)
    else $error("beat done while idle");
  busy_end_a: assert property ($fell(ACC_BUSY) |-> $past(ACC_BEAT_DONE))
    else $error("busy dropped early");
endmodule // emw_top_checker
bind emw_top emw_top_checker chk (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .ACC_START(ACC_START),
  .ACC_BUSY(ACC_BUSY), .ACC_BEAT_DONE(ACC_BEAT_DONE), .EXT_WAIT_B(EXT_WAIT_B),
  .LOG_ADDR(LOG_ADDR), .COL_PHASE(COL_PHASE), .AP_LEVEL(AP_LEVEL), .MEM_ADDR(MEM_ADDR));

// File: bench/external_memory_wait_and_sdram_mux_tb.sv
`timescale 1ns/1ps
`include "emw_regs.svh"
module external_memory_wait_and_sdram_mux_tb;
  typedef struct packed {logic [25:0] a; logic c; logic p; logic [17:0] e;} emw_mux_row_t;
  typedef struct packed {logic [31:0] d; logic [7:0] x; int f;} emw_acc_row_t;
  logic clk, rst_b, awv, wv, bre, arv, rre, st, go, col, ap;
  logic awr, wr_rdy, bv, arr, rv, done, busy, ewb;
  logic [31:0] awa, wd, ara, rdat;
  logic [25:0] la;
  logic [17:0] ma;
  logic [7:0] wl;
  logic [1:0] brs, rrs;
  logic [1:0] bts;
  int mismatches, cmp_count;
  emw_mux_row_t mux_rows [5] = '{'{26'h2a55a5a, 1'b0, 1'b0, 18'h2a55a},
    '{26'h2a55a5a, 1'b1, 1'b1, 18'h16a5a}, '{26'h2a55a5a, 1'b1, 1'b0, 18'h1625a},
    '{26'h15aa5a5, 1'b1, 1'b1, 18'h29da5}, '{26'h15aa5a5, 1'b0, 1'b1, 18'h15aa5}};
  emw_acc_row_t acc_rows [5] = '{'{32'h40, 8'h0, 2}, '{32'h101c0, 8'h0, 5},
    '{32'h202c0, 8'h0, 7}, '{32'h30040, 8'h8, 2}, '{32'h0, 8'h0, 2}};
  emw_top dut (.REF_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(brs), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .ACC_START(st),
    .ACC_BEATS(bts), .ACC_BEAT_DONE(done), .ACC_BUSY(busy), .EXT_WAIT_B(ewb),
    .LOG_ADDR(la), .COL_PHASE(col), .AP_LEVEL(ap), .MEM_ADDR(ma));
  emw_mem_model mem (.clk(clk), .go(go), .len(wl), .mem_addr(ma), .ext_wait_b(ewb), .bank());
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!(bv && bre));
    chk("bresp", 32'h0, {30'h0, brs});
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rre));
    d = rdat;
    r = rrs;
    rre <= 1'b0;
  endtask
  task automatic acc(input logic [7:0] x, input logic [1:0] b, output int first, output int gap);
    int n, k, last;
    @(posedge clk);
    go <= (x != 8'h0); wl <= x;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    st <= 1'b1;
    bts <= b;
    @(posedge clk);
    st <= 1'b0;
    n = 0; k = 0; last = 0; first = 0; gap = 0;
    while (k <= int'(b)) begin
      @(negedge clk);
      n++;
      if (done === 1'b1) begin
        if (k == 0) first = n;
        else gap = n - last;
        last = n;
        k++;
      end
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int f, g;
    rst_b = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; st = 0; go = 0;
    col = 0; ap = 0; awa = 0; wd = 0; ara = 0; la = 0; wl = 0; bts = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(`EMW_WCR_OFS, d, r);
    chk("wcr reset", 32'h0000_0500, d);
    rd(`EMW_STAT_OFS, d, r);
    chk("status idle", 32'h0000_0004, d);
    rd(32'h8, d, r);
    chk("unmapped resp", {30'h0, `EMW_RESP_DECERR}, {30'h0, r});
    wr(`EMW_WCR_OFS, 32'hffff_ffff);
    rd(`EMW_WCR_OFS, d, r);
    chk("wcr reserved", 32'h0003_07c0, d);
    foreach (mux_rows[i]) begin
      @(posedge clk);
      la <= mux_rows[i].a; col <= mux_rows[i].c; ap <= mux_rows[i].p;
      repeat (2) @(posedge clk);
      chk("mem addr", {14'h0, mux_rows[i].e}, {14'h0, ma});
    end
    foreach (acc_rows[i]) begin
      wr(`EMW_WCR_OFS, acc_rows[i].d);
      acc(acc_rows[i].x, 2'h3, f, g);
      chk("first beat", 32'(acc_rows[i].f), 32'(f));
      chk("later gap", 32'h2 + 32'(acc_rows[i].d[17:16]), 32'(g));
    end
    wr(`EMW_WCR_OFS, 32'h0);
    acc(8'h8, 2'h0, f, g);
    chk("wait stretch", 32'h9, 32'(f));
    chk("single beat gap", 32'h0, 32'(g));
    wr(`EMW_WCR_OFS, 32'h0000_0780);
    @(posedge clk);
    st <= 1'b1;
    bts <= 2'h3;
    @(posedge clk);
    st <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("busy after reset", 32'h0, {31'h0, busy});
    chk("readies after reset", 32'h7, {29'h0, awr, wr_rdy, arr});
    rd(`EMW_WCR_OFS, d, r);
    chk("wcr after reset", `EMW_WCR_RST, d);
    final_report();
  end
endmodule // external_memory_wait_and_sdram_mux_tb
